// File: hw/sarcr_consts.svh
/*
 * Constants for the converter control and serial readout block: timing counts,
 * widths and frame layout.
 * Assumes a 50 MHz system clock and a host that clocks the readout itself.
 */
`ifndef SARCR_CONSTS_SVH
`define SARCR_CONSTS_SVH

`define SARCR_SYS_FREQ_KHZ      50000
`define SARCR_OSC_FREQ_KHZ      4000
`define SARCR_OSC_DIV           (`SARCR_SYS_FREQ_KHZ / `SARCR_OSC_FREQ_KHZ)
`define SARCR_CONV_MAX_NS       3700
`define SARCR_CONV_MAX_CYCLES   ((`SARCR_CONV_MAX_NS * `SARCR_SYS_FREQ_KHZ) / 1000000)
`define SARCR_RES_BITS          10
`define SARCR_TAIL_BITS         2
`define SARCR_FRAME_BITS        (`SARCR_RES_BITS + `SARCR_TAIL_BITS)
`define SARCR_FIFO_DEPTH        8
`define SARCR_OSC_W             4
`define SARCR_CONV_W            8
`define SARCR_RISE_W            4

`endif

// File: hw/sarcr_pkg.sv
/*
 * Types shared by the converter control block.
 * Assumes the constants header is on the include path.
 */
`include "sarcr_consts.svh"

package sarcr_pkg;

    typedef enum logic [3:0] {
        SARCR_SHUTDOWN = 4'h1,
        SARCR_TRACK    = 4'h2,
        SARCR_CONVERT  = 4'h4,
        SARCR_FINISH   = 4'h8
    } sarcr_mode_t;

    typedef struct packed {
        sarcr_mode_t                   mode;
        logic [1:0]                    strobe_sync;
        logic                          strobe_prev;
        logic [1:0]                    sclk_sync;
        logic                          sclk_prev;
        logic [1:0]                    variant_sync;
        logic [`SARCR_OSC_W-1:0]       osc_cnt;
        logic [`SARCR_CONV_W-1:0]      conv_cnt;
        logic [`SARCR_RES_BITS-1:0]    code;
        logic [`SARCR_RES_BITS-1:0]    mask;
        logic [`SARCR_RES_BITS-1:0]    dac;
        logic [`SARCR_RES_BITS-1:0]    result;
        logic                          sel_second;
        logic                          frame_act;
        logic                          frame_read;
        logic [`SARCR_FRAME_BITS-1:0]  shift;
        logic [`SARCR_RISE_W-1:0]      rise_cnt;
        logic                          dout;
        logic                          dout_oe_n;
    } sarcr_state_t;

endpackage

// File: hw/sarcr_fifo.sv
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes a power-of-two depth so the pointers wrap by themselves.
 */
`timescale 1ns/1ns

module sarcr_fifo
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst_sys_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } sarcr_fifo_state_t;

    sarcr_fifo_state_t s_r;
    sarcr_fifo_state_t s_nxt;
    logic              push;
    logic              pop;

    assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop)
        begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop)
        begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

// File: hw/sarcr_top.sv
/*
 * Digital control of a ten-bit successive approximation converter: strobe
 * decoding, track and hold sequencing, bit search and serial readout.
 * Assumes an analogue comparator on the same clock, and a host that drives the
 * strobe and serial clock asynchronously; both pins are sampled here.
 */
`timescale 1ns/1ns
`include "sarcr_consts.svh"

module sarcr_top
    import sarcr_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       conversion_strobe,
    input  wire logic                       sclk,
    input  wire logic                       comp_above,
    input  wire logic                       two_channel_variant,
    output logic                            dout,
    output logic                            dout_oe_n,
    output logic                            powered_up,
    output logic                            track_en,
    output logic                            hold_en,
    output logic                            second_input_channel,
    output logic [`SARCR_RES_BITS-1:0]      dac_code
);

    sarcr_state_t                 s_r;
    sarcr_state_t                 s_nxt;
    logic [1:0]                   rst_ff_r;
    logic                         rst_sys_n;
    logic                         fifo_in_valid;
    logic                         fifo_in_ready;
    logic                         fifo_out_valid;
    logic                         fifo_out_ready;
    logic [`SARCR_RES_BITS-1:0]   fifo_out_data;

    function automatic logic edge_seen(input logic prev, input logic cur, input logic rising);
        edge_seen = rising ? (cur && !prev) : (!cur && prev);
    endfunction

    // Offset binary from the bit search becomes two's complement by flipping the top bit.
    function automatic logic [`SARCR_RES_BITS-1:0] format_result(
        input logic [`SARCR_RES_BITS-1:0] raw,
        input logic                       bipolar
    );
        format_result = raw;
        if (bipolar)
        begin
            format_result[`SARCR_RES_BITS-1] = ~raw[`SARCR_RES_BITS-1];
        end
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_ff_r <= 2'h0;
        end
        else
        begin
            rst_ff_r <= {rst_ff_r[0], 1'b1};
        end
    end

    assign rst_sys_n = rst_ff_r[1];

    // The stall on a full FIFO holds the finished result rather than dropping it.
    assign fifo_in_valid  = (s_r.mode == SARCR_FINISH);
    assign fifo_out_ready = (s_r.mode == SARCR_SHUTDOWN) && !s_r.frame_act
                            && !edge_seen(s_r.strobe_prev, s_r.strobe_sync[1], 1'b1);

    sarcr_fifo
    #(
        .WIDTH (`SARCR_RES_BITS),
        .DEPTH (`SARCR_FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys   (clk_sys),
        .rst_sys_n (rst_sys_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (s_r.result),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_comb
    begin
        logic strobe_rise;
        logic strobe_fall;
        logic sclk_rise;
        logic sclk_fall;
        logic osc_tick;
        logic [`SARCR_RES_BITS-1:0] code_v;

        s_nxt = s_r;
        s_nxt.strobe_sync  = {s_r.strobe_sync[0], conversion_strobe};
        s_nxt.strobe_prev  = s_r.strobe_sync[1];
        s_nxt.sclk_sync    = {s_r.sclk_sync[0], sclk};
        s_nxt.sclk_prev    = s_r.sclk_sync[1];
        s_nxt.variant_sync = {s_r.variant_sync[0], two_channel_variant};

        strobe_rise = edge_seen(s_r.strobe_prev, s_r.strobe_sync[1], 1'b1);
        strobe_fall = edge_seen(s_r.strobe_prev, s_r.strobe_sync[1], 1'b0);
        sclk_rise   = edge_seen(s_r.sclk_prev, s_r.sclk_sync[1], 1'b1);
        sclk_fall   = edge_seen(s_r.sclk_prev, s_r.sclk_sync[1], 1'b0);
        osc_tick    = (s_r.osc_cnt == `SARCR_OSC_W'(`SARCR_OSC_DIV - 1));
        code_v      = s_r.code;

        if (strobe_rise)
        begin
            // A rise during a conversion aborts it; that is how the double pulse works.
            s_nxt.sel_second = !s_r.frame_read;
            s_nxt.frame_read = 1'b0;
            s_nxt.frame_act  = 1'b0;
            s_nxt.mode       = SARCR_TRACK;
            s_nxt.dout       = 1'b0;
            s_nxt.dout_oe_n  = 1'b0;
        end
        else
        begin
            unique case (s_r.mode)
                SARCR_SHUTDOWN:
                begin
                    // Loading only on a real pop keeps a live frame from being reloaded.
                    if (fifo_out_valid && fifo_out_ready)
                    begin
                        s_nxt.shift      = {fifo_out_data, `SARCR_TAIL_BITS'(0)};
                        s_nxt.dout       = fifo_out_data[`SARCR_RES_BITS-1];
                        s_nxt.dout_oe_n  = 1'b0;
                        s_nxt.frame_act  = 1'b1;
                        s_nxt.rise_cnt   = '0;
                    end
                end
                SARCR_TRACK:
                begin
                    if (strobe_fall)
                    begin
                        s_nxt.mode     = SARCR_CONVERT;
                        s_nxt.code     = '0;
                        s_nxt.mask     = `SARCR_RES_BITS'(1) << (`SARCR_RES_BITS - 1);
                        s_nxt.dac      = `SARCR_RES_BITS'(1) << (`SARCR_RES_BITS - 1);
                        s_nxt.osc_cnt  = '0;
                        s_nxt.conv_cnt = '0;
                    end
                end
                SARCR_CONVERT:
                begin
                    s_nxt.conv_cnt = s_r.conv_cnt + 1'b1;
                    s_nxt.osc_cnt  = osc_tick ? '0 : s_r.osc_cnt + 1'b1;
                    if (osc_tick)
                    begin
                        if (comp_above)
                        begin
                            code_v = s_r.code | s_r.mask;
                        end
                        s_nxt.code = code_v;
                        s_nxt.mask = s_r.mask >> 1;
                        s_nxt.dac  = code_v | (s_r.mask >> 1);
                    end
                    // The cycle bound is a guard only; the tick sequence ends well before it.
                    if ((osc_tick && s_r.mask[0])
                        || s_r.conv_cnt == `SARCR_CONV_W'(`SARCR_CONV_MAX_CYCLES - 8))
                    begin
                        s_nxt.result = format_result(code_v,
                                       s_r.sel_second && !s_r.variant_sync[1]);
                        s_nxt.mode   = SARCR_FINISH;
                    end
                end
                SARCR_FINISH:
                begin
                    if (fifo_in_ready)
                    begin
                        s_nxt.mode = SARCR_SHUTDOWN;
                    end
                end
            endcase

            if (s_r.frame_act && sclk_fall)
            begin
                s_nxt.shift = s_r.shift << 1;
                s_nxt.dout  = s_r.shift[`SARCR_FRAME_BITS-2];
            end
            if (s_r.frame_act && sclk_rise)
            begin
                s_nxt.rise_cnt = s_r.rise_cnt + 1'b1;
                if (s_r.rise_cnt == `SARCR_RISE_W'(`SARCR_FRAME_BITS - 1))
                begin
                    s_nxt.dout_oe_n  = 1'b1;
                    s_nxt.frame_act  = 1'b0;
                    s_nxt.frame_read = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            s_r            <= '0;
            s_r.mode       <= SARCR_SHUTDOWN;
            s_r.frame_read <= 1'b1;
            s_r.dout_oe_n  <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign dout                 = s_r.dout;
    assign dout_oe_n            = s_r.dout_oe_n;
    assign powered_up           = (s_r.mode != SARCR_SHUTDOWN);
    assign track_en             = (s_r.mode == SARCR_TRACK);
    assign hold_en              = (s_r.mode == SARCR_CONVERT) || (s_r.mode == SARCR_FINISH);
    assign second_input_channel = s_r.sel_second;
    assign dac_code             = s_r.dac;

endmodule

// File: dv/sarcr_top_sva.sv
/*
 * Concurrent checks on the pins of the converter control top.
 * Assumes host pins change away from the rising clock edge.
 */
`timescale 1ns/1ns
`include "sarcr_consts.svh"

module sarcr_top_sva
(
    input wire logic                       clk_sys,
    input wire logic                       rst_n,
    input wire logic                       conversion_strobe,
    input wire logic                       sclk,
    input wire logic                       dout,
    input wire logic                       dout_oe_n,
    input wire logic                       powered_up,
    input wire logic                       track_en,
    input wire logic                       hold_en,
    input wire logic [`SARCR_RES_BITS-1:0] dac_code
);
    logic [3:0] rise_n_r;
    logic [3:0] since_fall_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Counts serial rises per frame so the tail and release points can be located.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_n_r     <= 4'h0;
            since_fall_r <= 4'hF;
        end
        else
        begin
            if ($rose(conversion_strobe))
                rise_n_r <= 4'h0;
            else if ($rose(sclk) && rise_n_r != 4'hF)
                rise_n_r <= rise_n_r + 4'h1;
            if ($fell(sclk))
                since_fall_r <= 4'h0;
            else if (since_fall_r != 4'hF)
                since_fall_r <= since_fall_r + 4'h1;
        end
    end

    property p_idle;
        !conversion_strobe [*8] |-> !track_en;
    endproperty
    a_idle: assert property (p_idle) else $error("track while strobe low");
    property p_wake;
        $rose(conversion_strobe) |-> ##[3:4] (track_en && powered_up && !dout_oe_n && !dout);
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on strobe rise");
    property p_hold;
        $fell(conversion_strobe) && track_en
            |-> ##[3:5] (hold_en && !track_en && dac_code == 10'h200);
    endproperty
    a_hold: assert property (p_hold) else $error("no hold on strobe fall");
    property p_conv;
        $fell(conversion_strobe) && track_en
            |-> ##[100:185] (!powered_up && !hold_en && !dout_oe_n);
    endproperty
    a_conv: assert property (p_conv) else $error("conversion too slow");
    property p_pace;
        hold_en && $changed(dac_code) |-> ##1 (!hold_en || $stable(dac_code)) [*8];
    endproperty
    a_pace: assert property (p_pace) else $error("trial steps too fast");
    property p_shift;
        $changed(dout) && rise_n_r != 4'h0 |-> since_fall_r <= 4'h6;
    endproperty
    a_shift: assert property (p_shift) else $error("data moved off falling edge");
    property p_tail;
        $fell(sclk) && (rise_n_r == 4'hA || rise_n_r == 4'hB) |-> ##5 (!dout && !dout_oe_n);
    endproperty
    a_tail: assert property (p_tail) else $error("tail bit not zero");
    property p_release;
        $rose(sclk) && rise_n_r == 4'hB |-> ##[3:5] dout_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("output not released");
endmodule

bind sarcr_top sarcr_top_sva u_sva (.clk_sys, .rst_n, .conversion_strobe, .sclk, .dout,
    .dout_oe_n, .powered_up, .track_en, .hold_en, .dac_code);

// File: dv/sarcr_host_model.sv
/*
 * Host that drives the strobe and clocks the readout in mode 0.
 * Assumes it is called from the bench and steps on falling clock edges.
 */
`timescale 1ns/1ns

module sarcr_host_model
(
    input  wire logic clk_sys,
    input  wire logic dout_line,
    output logic      conversion_strobe,
    output logic      sclk
);
    initial
    begin
        conversion_strobe = 1'b0;
        sclk              = 1'b0;
    end

    task automatic convert(input logic second);
        @(negedge clk_sys);
        if (second)
        begin
            conversion_strobe = 1'b1;
            repeat (2) @(negedge clk_sys);
            conversion_strobe = 1'b0;
            repeat (3) @(negedge clk_sys);
        end
        conversion_strobe = 1'b1;
        repeat (75) @(negedge clk_sys);
        conversion_strobe = 1'b0;
        repeat (190) @(negedge clk_sys);
    endtask

    // The serial clock stays low between reads, as a real master leaves it.
    task automatic read(input int n, output logic [15:0] bits);
        bits = 16'h0000;
        repeat (n)
        begin
            sclk = 1'b1;
            bits = {bits[14:0], dout_line};
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
            repeat (4) @(negedge clk_sys);
        end
    endtask
endmodule

// File: dv/sarcr_tb_top.sv
/*
 * Self-checking bench for the converter control top and its FIFO.
 * Assumes a pulled-up data line and a comparator modelled from the input code.
 */
`timescale 1ns/1ns

module sarcr_tb_top;
    logic        clk_sys;
    logic        rst_n;
    logic        comp_above;
    logic        two_channel_variant;
    logic        conversion_strobe;
    logic        sclk;
    logic        dout;
    logic        dout_oe_n;
    logic        powered_up;
    logic        track_en;
    logic        hold_en;
    logic        second_input_channel;
    logic [9:0]  dac_code;
    logic [9:0]  vin;
    logic [15:0] got;
    int          miscompares;
    int          cmp_count;
    wire         dout_line = dout_oe_n ? 1'b1 : dout;

    // The input sits half a step above vin so either comparator reading gives vin.
    assign comp_above = ({vin, 1'b1} > {dac_code, 1'b0});

    sarcr_top dut (.clk_sys, .rst_n, .conversion_strobe, .sclk, .comp_above,
        .two_channel_variant, .dout, .dout_oe_n, .powered_up, .track_en, .hold_en,
        .second_input_channel, .dac_code);
    sarcr_host_model u_host (.clk_sys, .dout_line, .conversion_strobe, .sclk);

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic run_frame(input logic [9:0] v, input logic second, input logic var2);
        logic [9:0] res;
        res = (second && !var2) ? v ^ 10'h200 : v;
        vin = v;
        two_channel_variant = var2;
        u_host.convert(second);
        check("channel", {15'h0000, second_input_channel}, {15'h0000, second});
        u_host.read(12, got);
        check("frame", got, {4'h0, res, 2'b00});
        repeat (8) @(negedge clk_sys);
        check("released", {15'h0000, dout_oe_n}, 16'h0001);
    endtask

    task automatic t_reset();
        check("idle", {12'h000, powered_up, track_en, hold_en, dout_oe_n}, 16'h0001);
    endtask

    task automatic t_unipolar();
        run_frame(10'h000, 1'b0, 1'b0);
        run_frame(10'h3FF, 1'b0, 1'b0);
        run_frame(10'h2A5, 1'b0, 1'b0);
    endtask

    task automatic t_bipolar();
        run_frame(10'h155, 1'b1, 1'b0);
        run_frame(10'h155, 1'b1, 1'b1);
    endtask

    // A short read leaves the next single pulse on the second input.
    task automatic t_short();
        vin = 10'h0F3;
        two_channel_variant = 1'b0;
        u_host.convert(1'b0);
        u_host.read(8, got);
        check("first byte", got, 16'h003C);
        u_host.convert(1'b0);
        check("channel", {15'h0000, second_input_channel}, 16'h0001);
        u_host.read(16, got);
        check("word", got, {10'h2F3, 2'b00, 4'hF});
        run_frame(10'h001, 1'b0, 1'b0);
    endtask

    // One result passes the FIFO to the serializer and is not replayed after release.
    task automatic t_fifo();
        vin = 10'h26A;
        two_channel_variant = 1'b0;
        u_host.convert(1'b0);
        check("result ready", {12'h000, powered_up, hold_en, dout_oe_n, dout_line},
              16'h0001);
        u_host.read(12, got);
        check("fifo frame", got, {4'h0, 10'h26A, 2'h0});
        repeat (30) @(negedge clk_sys);
        check("fifo empty", {14'h0000, dout_oe_n, powered_up}, 16'h0002);
    endtask

    initial
    begin
        rst_n = 1'b0;
        vin = 10'h000;
        two_channel_variant = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        t_reset();
        t_unipolar();
        t_bipolar();
        t_short();
        t_fifo();
        close_out();
    end

    // Several times the expected run; a hang ends the run as a failure.
    initial
    begin
        #400000;
        miscompares++;
        close_out();
    end
endmodule
